// *** src/revf_flags.v ***
// Radio event flags, pin routing, clock output divider and receive timeouts behind an AHB-Lite slave
//
// Behaviour
// - Six two-bit pin selectors, reset zero
// - Clock output divides crystal, RC, or off
// - Mode settled flag, cleared on mode change
// - Receive settled after measurement, gain, correction
// - Transmit settled after amplifier ramp
// - Synth locked follows lock in FS/RX/TX
// - Signal flag on threshold, host clearable
// - Timeout flag from either receive timeout
// - Auto sequencing flag tracks intermediate mode
// - Pattern match flag, clearable in continuous
// - Brimming flag exactly at 66 bytes
// - Occupied flag while buffer nonempty
// - Above-mark flag when count exceeds mark
// - Overflow flag; writing one flushes buffer
// - Frame transmitted flag, cleared leaving transmit
// - Frame received after last byte, checksum
// - Checksum pass flag until buffer empties
// - Eight-bit signal trigger level, reset E4
// - Receive start timeout, 16 bit units
// - Strength value is half-dB magnitude
// - Failed checksum flushes and restarts unless kept
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "revf_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Bit-period timeout counter
module revf_wait (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire run,
  input wire tick,
  input wire [7:0] limit,
  output reg fire
);
  reg [11:0] cnt_reg;
  reg done_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 12'h000;
      done_reg <= 1'b0;
      fire <= 1'b0;
    end else if (!run || start) begin
      cnt_reg <= 12'h000;
      done_reg <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (tick && (limit != `REVF_RST_TIMEOUT) && !done_reg) begin
        cnt_reg <= cnt_reg + 12'h001;
        if (cnt_reg == ({limit, `REVF_TO_UNIT} - 12'h001)) begin
          fire <= 1'b1;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule // revf_wait

////////////////////////////////////////////////////////////////////////////////
module revf_flags (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [2:0] op_mode,
  input wire xo_running,
  input wire synth_lock_in,
  input wire rssi_sampling_started,
  input wire pa_ramp_done,
  input wire rx_chain_done,
  input wire rssi_valid,
  input wire [7:0] signal_strength_value,
  input wire intermediate_mode,
  input wire pattern_detect,
  input wire [6:0] buffer_count,
  input wire [6:0] buffer_mark,
  input wire buffer_overrun,
  input wire frame_sent,
  input wire last_byte,
  input wire checksum_good,
  input wire checksum_enable,
  input wire checksum_fail_keep,
  input wire continuous_mode,
  input wire bit_tick,
  input wire crystal_level,
  input wire rc_osc_level,
  output reg [5:0] general_output_pin,
  output reg divided_clock_pin,
  output reg rc_osc_enable,
  output reg buffer_flush,
  output reg rx_restart
);
  reg [7:0] pin_sel_a_reg;
  reg [3:0] pin_sel_b_reg;
  reg [2:0] divided_clock_select;
  reg [7:0] signal_trigger_level;
  reg [7:0] receive_start_wait;
  reg [7:0] post_signal_wait;
  reg mode_settled_flag;
  reg receive_settled_flag;
  reg transmit_settled_flag;
  reg synth_locked_flag;
  reg signal_flag;
  reg timeout_flag;
  reg auto_sequencing_flag;
  reg pattern_match_flag;
  reg buffer_brimming_flag;
  reg buffer_occupied_flag;
  reg buffer_above_mark_flag;
  reg buffer_overflow_flag;
  reg frame_transmitted_flag;
  reg frame_received_flag;
  reg checksum_pass_flag;
  reg [2:0] mode_reg;
  reg was_occupied_reg;
  reg armed_reg;
  reg wr_pend_reg;
  reg [5:0] wr_idx_reg;
  reg [5:0] rd_idx_reg;
  reg rd_pend_reg;
  reg xtal_q_reg;
  reg [4:0] div_cnt_reg;
  reg [31:0] rdata_next;
  reg [5:0] gpo_next;
  reg clk_next;
  integer i;

  wire in_rx = (op_mode == `REVF_MODE_RX);
  wire in_tx = (op_mode == `REVF_MODE_TX);
  wire in_sleep = (op_mode == `REVF_MODE_SLEEP);
  wire mode_change = (op_mode != mode_reg);
  wire rx_entry = in_rx && (mode_reg != `REVF_MODE_RX);
  wire emptied = was_occupied_reg && (buffer_count == 7'h00);
  wire bus_take = hsel && htrans[1] && hready;
  wire addr_ok = (haddr[31:8] == 24'h000000);
  wire [7:0] wbyte = hwdata[7:0];
  wire wr_f1 = wr_pend_reg && (wr_idx_reg == `REVF_IDX_RADIO_FLAGS);
  wire wr_f2 = wr_pend_reg && (wr_idx_reg == `REVF_IDX_BUF_FLAGS);
  wire host_clr_sig = wr_f1 && wbyte[`REVF_F1_SIGNAL];
  wire host_clr_pat = wr_f1 && wbyte[`REVF_F1_PATTERN] && continuous_mode;
  wire host_flush = wr_f2 && wbyte[`REVF_F2_OVERFLOW];
  // Strength is a half-dB magnitude, so a stronger signal is a smaller value
  wire sig_hit = in_rx && rssi_valid && (signal_strength_value < signal_trigger_level);
  wire sig_event = sig_hit && !signal_flag;
  wire crc_bad = checksum_enable && !checksum_good;
  wire crc_reject = in_rx && last_byte && crc_bad && !checksum_fail_keep;
  wire to1_fire;
  wire to2_fire;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive timeouts
  revf_wait u_start_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(rx_entry),
    .run(in_rx && !signal_flag),
    .tick(bit_tick),
    .limit(receive_start_wait),
    .fire(to1_fire)
  );

  revf_wait u_signal_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(sig_event),
    .run(in_rx && armed_reg && !frame_received_flag),
    .tick(bit_tick),
    .limit(post_signal_wait),
    .fire(to2_fire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait, reads take one so fresh flags are seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      rd_idx_reg <= 6'h00;
    end else begin
      hresp <= 1'b0;
      wr_pend_reg <= bus_take && hwrite && addr_ok;
      rd_pend_reg <= 1'b0;
      if (bus_take) begin
        wr_idx_reg <= haddr[7:2];
        rd_idx_reg <= addr_ok ? haddr[7:2] : 6'h00;
      end
      if (bus_take && !hwrite) begin
        hreadyout <= 1'b0;
        rd_pend_reg <= 1'b1;
      end else begin
        hreadyout <= 1'b1;
      end
      if (rd_pend_reg) begin
        hrdata <= rdata_next;
      end
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    case (rd_idx_reg)
      `REVF_IDX_PIN_SEL_A: rdata_next[7:0] = pin_sel_a_reg;
      `REVF_IDX_PIN_SEL_B: rdata_next[7:0] = {pin_sel_b_reg, 1'b0, divided_clock_select};
      `REVF_IDX_RADIO_FLAGS: rdata_next[7:0] = {mode_settled_flag, receive_settled_flag,
        transmit_settled_flag, synth_locked_flag, signal_flag, timeout_flag,
        auto_sequencing_flag, pattern_match_flag};
      `REVF_IDX_BUF_FLAGS: rdata_next[7:0] = {buffer_brimming_flag, buffer_occupied_flag,
        buffer_above_mark_flag, buffer_overflow_flag, frame_transmitted_flag,
        frame_received_flag, checksum_pass_flag, 1'b0};
      `REVF_IDX_SIG_TRIG: rdata_next[7:0] = signal_trigger_level;
      `REVF_IDX_RX_START_TO: rdata_next[7:0] = receive_start_wait;
      `REVF_IDX_SIG_WAIT_TO: rdata_next[7:0] = post_signal_wait;
      default: rdata_next = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sel_a_reg <= `REVF_RST_PIN_SEL_A;
      pin_sel_b_reg <= `REVF_RST_PIN_SEL_B;
      divided_clock_select <= `REVF_RST_CLK_SEL;
      signal_trigger_level <= `REVF_RST_SIG_TRIG;
      receive_start_wait <= `REVF_RST_TIMEOUT;
      post_signal_wait <= `REVF_RST_TIMEOUT;
    end else if (wr_pend_reg) begin
      case (wr_idx_reg)
        `REVF_IDX_PIN_SEL_A: pin_sel_a_reg <= wbyte;
        `REVF_IDX_PIN_SEL_B: begin
          pin_sel_b_reg <= wbyte[7:4];
          divided_clock_select <= wbyte[2:0];
        end
        `REVF_IDX_SIG_TRIG: signal_trigger_level <= wbyte;
        `REVF_IDX_RX_START_TO: receive_start_wait <= wbyte;
        `REVF_IDX_SIG_WAIT_TO: post_signal_wait <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Radio event flags; a hardware set always wins over a host clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= `REVF_MODE_SLEEP;
      mode_settled_flag <= 1'b1;
      receive_settled_flag <= 1'b0;
      transmit_settled_flag <= 1'b0;
      synth_locked_flag <= 1'b0;
      signal_flag <= 1'b0;
      timeout_flag <= 1'b0;
      auto_sequencing_flag <= 1'b0;
      pattern_match_flag <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      mode_reg <= op_mode;
      if (mode_change) begin
        mode_settled_flag <= 1'b0;
      end else begin
        case (op_mode)
          `REVF_MODE_SLEEP: mode_settled_flag <= 1'b1;
          `REVF_MODE_STANDBY: mode_settled_flag <= mode_settled_flag | xo_running;
          `REVF_MODE_FS: mode_settled_flag <= mode_settled_flag | synth_lock_in;
          `REVF_MODE_RX: mode_settled_flag <= mode_settled_flag | rssi_sampling_started;
          `REVF_MODE_TX: mode_settled_flag <= mode_settled_flag | pa_ramp_done;
          default: mode_settled_flag <= mode_settled_flag;
        endcase
      end
      receive_settled_flag <= in_rx && (receive_settled_flag || rx_chain_done);
      transmit_settled_flag <= in_tx && (transmit_settled_flag || pa_ramp_done);
      synth_locked_flag <= (op_mode == `REVF_MODE_FS || in_rx || in_tx) && synth_lock_in;
      if (sig_hit) begin
        signal_flag <= 1'b1;
      end else if (!in_rx || host_clr_sig) begin
        signal_flag <= 1'b0;
      end
      if (!in_rx || frame_received_flag) begin
        armed_reg <= 1'b0;
      end else if (sig_event) begin
        armed_reg <= 1'b1;
      end
      if (to1_fire || to2_fire) begin
        timeout_flag <= 1'b1;
      end else if (!in_rx || emptied || host_flush) begin
        timeout_flag <= 1'b0;
      end
      // Sleep lag is one cycle, well inside what the host may observe
      auto_sequencing_flag <= intermediate_mode;
      if (in_rx && pattern_detect) begin
        pattern_match_flag <= 1'b1;
      end else if (!in_rx || emptied || host_clr_pat || host_flush) begin
        pattern_match_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer event flags
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      was_occupied_reg <= 1'b0;
      buffer_brimming_flag <= 1'b0;
      buffer_occupied_flag <= 1'b0;
      buffer_above_mark_flag <= 1'b0;
      buffer_overflow_flag <= 1'b0;
      frame_transmitted_flag <= 1'b0;
      frame_received_flag <= 1'b0;
      checksum_pass_flag <= 1'b0;
      buffer_flush <= 1'b0;
      rx_restart <= 1'b0;
    end else begin
      was_occupied_reg <= (buffer_count != 7'h00);
      buffer_brimming_flag <= (buffer_count == `REVF_BUF_DEPTH);
      buffer_occupied_flag <= (buffer_count != 7'h00);
      buffer_above_mark_flag <= (buffer_count > buffer_mark);
      if (buffer_overrun && !in_sleep) begin
        buffer_overflow_flag <= 1'b1;
      end else if (host_flush) begin
        buffer_overflow_flag <= 1'b0;
      end
      if (in_tx && frame_sent) begin
        frame_transmitted_flag <= 1'b1;
      end else if (!in_tx) begin
        frame_transmitted_flag <= 1'b0;
      end
      if (in_rx && last_byte && (!crc_bad || checksum_fail_keep)) begin
        frame_received_flag <= 1'b1;
      end else if (emptied || host_flush) begin
        frame_received_flag <= 1'b0;
      end
      if (in_rx && last_byte && checksum_enable && checksum_good) begin
        checksum_pass_flag <= 1'b1;
      end else if (emptied || host_flush) begin
        checksum_pass_flag <= 1'b0;
      end
      buffer_flush <= host_flush || crc_reject;
      rx_restart <= crc_reject;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin routing; the table changes between continuous and packet operation
  wire [23:0] pkt_tab = {
    mode_settled_flag, buffer_brimming_flag, buffer_above_mark_flag, buffer_occupied_flag,
    mode_settled_flag, timeout_flag, signal_flag, synth_locked_flag,
    synth_locked_flag, auto_sequencing_flag, pattern_match_flag, buffer_occupied_flag,
    synth_locked_flag, timeout_flag, signal_flag, buffer_brimming_flag,
    synth_locked_flag, signal_flag, timeout_flag, buffer_above_mark_flag,
    synth_locked_flag, pattern_match_flag, checksum_pass_flag,
    in_tx ? frame_transmitted_flag : frame_received_flag};
  wire [23:0] cont_tab = {
    mode_settled_flag, divided_clock_pin, signal_flag, auto_sequencing_flag,
    mode_settled_flag, synth_locked_flag, receive_settled_flag, transmit_settled_flag,
    synth_locked_flag, timeout_flag, signal_flag, mode_settled_flag,
    synth_locked_flag, timeout_flag, signal_flag, receive_settled_flag,
    synth_locked_flag, auto_sequencing_flag, signal_flag, pattern_match_flag,
    synth_locked_flag, receive_settled_flag, transmit_settled_flag, pattern_match_flag};

  always @* begin
    gpo_next = 6'h00;
    for (i = 0; i < 6; i = i + 1) begin
      if (i < 4) begin
        gpo_next[i] = continuous_mode ? cont_tab[i * 4 + pin_sel_a_reg[7 - 2 * i -: 2]]
                                      : pkt_tab[i * 4 + pin_sel_a_reg[7 - 2 * i -: 2]];
      end else begin
        gpo_next[i] = continuous_mode ? cont_tab[i * 4 + pin_sel_b_reg[11 - 2 * i -: 2]]
                                      : pkt_tab[i * 4 + pin_sel_b_reg[11 - 2 * i -: 2]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock output; dividers count crystal rising edges so the pin stays a flop
  always @* begin
    case (divided_clock_select)
      3'h0: clk_next = crystal_level;
      3'h1: clk_next = div_cnt_reg[0];
      3'h2: clk_next = div_cnt_reg[1];
      3'h3: clk_next = div_cnt_reg[2];
      3'h4: clk_next = div_cnt_reg[3];
      3'h5: clk_next = div_cnt_reg[4];
      `REVF_CLK_SEL_RC: clk_next = rc_osc_level;
      default: clk_next = 1'b0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_q_reg <= 1'b0;
      div_cnt_reg <= 5'h00;
      divided_clock_pin <= 1'b0;
      rc_osc_enable <= 1'b0;
      general_output_pin <= 6'h00;
    end else begin
      xtal_q_reg <= crystal_level;
      if (divided_clock_select == `REVF_CLK_SEL_OFF) begin
        div_cnt_reg <= 5'h00;
      end else if (crystal_level && !xtal_q_reg) begin
        div_cnt_reg <= div_cnt_reg + 5'h01;
      end
      divided_clock_pin <= clk_next;
      rc_osc_enable <= (divided_clock_select == `REVF_CLK_SEL_RC);
      general_output_pin <= gpo_next;
    end
  end
endmodule // revf_flags

// *** src/revf_regs.vh ***
// Register map, field positions, reset values and mode codes of the radio event flag block
`ifndef REVF_REGS_VH
`define REVF_REGS_VH
`define REVF_IDX_PIN_SEL_A 6'h25
`define REVF_IDX_PIN_SEL_B 6'h26
`define REVF_IDX_RADIO_FLAGS 6'h27
`define REVF_IDX_BUF_FLAGS 6'h28
`define REVF_IDX_SIG_TRIG 6'h29
`define REVF_IDX_RX_START_TO 6'h2A
`define REVF_IDX_SIG_WAIT_TO 6'h2B
`define REVF_RST_PIN_SEL_A 8'h00
`define REVF_RST_PIN_SEL_B 4'h0
`define REVF_RST_CLK_SEL 3'h7
`define REVF_RST_SIG_TRIG 8'hE4
`define REVF_RST_TIMEOUT 8'h00
`define REVF_CLK_SEL_RC 3'h6
`define REVF_CLK_SEL_OFF 3'h7
`define REVF_F1_MODE_SETTLED 7
`define REVF_F1_RX_SETTLED 6
`define REVF_F1_TX_SETTLED 5
`define REVF_F1_SYNTH_LOCKED 4
`define REVF_F1_SIGNAL 3
`define REVF_F1_TIMEOUT 2
`define REVF_F1_AUTO_SEQ 1
`define REVF_F1_PATTERN 0
`define REVF_F2_BRIMMING 7
`define REVF_F2_OCCUPIED 6
`define REVF_F2_ABOVE_MARK 5
`define REVF_F2_OVERFLOW 4
`define REVF_F2_FRAME_TX 3
`define REVF_F2_FRAME_RX 2
`define REVF_F2_CHECKSUM 1
`define REVF_BUF_DEPTH 7'h42
`define REVF_TO_UNIT 4'h0
`define REVF_MODE_SLEEP 3'h0
`define REVF_MODE_STANDBY 3'h1
`define REVF_MODE_FS 3'h2
`define REVF_MODE_TX 3'h3
`define REVF_MODE_RX 3'h4
`endif

// *** sim/revf_flags_properties.sv ***
// Concurrent checks on the bus answer and flush pulses of the event flag block
`timescale 1ns/1ps
`include "revf_regs.vh"
module revf_flags_properties (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [2:0] op_mode,
  input wire last_byte,
  input wire checksum_good,
  input wire checksum_enable,
  input wire checksum_fail_keep,
  input wire buffer_flush,
  input wire rx_restart
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_bad_frame;
    last_byte && checksum_enable && !checksum_good && op_mode == `REVF_MODE_RX;
  endsequence
  // Registers are one byte wide, so the upper lanes never carry data
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  a_read_wait: assert property (s_take and !hwrite |=> s_rd_answer)
    else $error("read answer not after one wait state");
  a_write_nowait: assert property (s_take and hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_fail_flush: assert property (s_bad_frame and !checksum_fail_keep |=> buffer_flush && rx_restart)
    else $error("failed frame not flushed and restarted");
  a_keep_frame: assert property (s_bad_frame and checksum_fail_keep |=> !rx_restart && !buffer_flush)
    else $error("kept frame was flushed");
  a_flush_single: assert property ($rose(buffer_flush) |=> !buffer_flush)
    else $error("flush pulse longer than one cycle");
  a_restart_single: assert property (rx_restart |=> !rx_restart)
    else $error("restart pulse longer than one cycle");
endmodule // revf_flags_properties

// *** sim/revf_radio_model.sv ***
// Radio side model: bit period ticks and the two oscillator levels
`timescale 1ns/1ps
module revf_radio_model (
  input wire hclk,
  input wire hresetn,
  output logic bit_tick,
  output logic crystal_level,
  output logic rc_osc_level
);
  logic [3:0] cnt;
  initial begin
    bit_tick = 1'b0;
    crystal_level = 1'b0;
    rc_osc_level = 1'b0;
    cnt = 4'h0;
  end
  // One tick every four clocks keeps the timeout windows short
  always @(posedge hclk) begin
    cnt <= cnt + 4'h1;
    bit_tick <= (cnt[1:0] == 2'h3);
    crystal_level <= cnt[0];
    rc_osc_level <= cnt[2];
  end
endmodule // revf_radio_model

// *** sim/tb_top.sv ***
// Self-checking bench for the radio event flag block
`timescale 1ns/1ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize, op_mode;
  logic xo_running, synth_lock_in, rssi_sampling_started, pa_ramp_done, rx_chain_done, rssi_valid;
  logic [7:0] signal_strength_value;
  logic intermediate_mode, pattern_detect, buffer_overrun, frame_sent, last_byte;
  logic [6:0] buffer_count, buffer_mark;
  logic checksum_good, checksum_enable, checksum_fail_keep, continuous_mode;
  wire hreadyout, hresp, bit_tick, crystal_level, rc_osc_level, divided_clock_pin, rc_osc_enable;
  wire buffer_flush, rx_restart;
  wire [31:0] hrdata;
  wire [5:0] general_output_pin;
  int mismatches, comparisons, flushes, f0;
  logic [31:0] ra [8] = '{32'h94, 32'h98, 32'h9C, 32'hA0, 32'hA4, 32'hA8, 32'hAC, 32'hB0};
  logic [31:0] rv [8] = '{32'h00, 32'h07, 32'h80, 32'h00, 32'hE4, 32'h00, 32'h00, 32'h00};
  revf_flags dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .op_mode, .xo_running, .synth_lock_in, .rssi_sampling_started,
    .pa_ramp_done, .rx_chain_done, .rssi_valid, .signal_strength_value, .intermediate_mode, .pattern_detect,
    .buffer_count, .buffer_mark, .buffer_overrun, .frame_sent, .last_byte, .checksum_good, .checksum_enable,
    .checksum_fail_keep, .continuous_mode, .bit_tick, .crystal_level, .rc_osc_level, .general_output_pin,
    .divided_clock_pin, .rc_osc_enable, .buffer_flush, .rx_restart);
  revf_radio_model radio_u (.hclk, .hresetn, .bit_tick, .crystal_level, .rc_osc_level);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) if (buffer_flush === 1'b1) flushes++;
  task print_verdict;
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bounded wait: a slave that never answers ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      print_verdict;
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    d = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    ahb(1'b1, a, v, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task pulse(input int k);
    case (k)
      0: frame_sent <= 1'b1;
      1: pattern_detect <= 1'b1;
      2: last_byte <= 1'b1;
      3: buffer_overrun <= 1'b1;
      default: rssi_valid <= 1'b1;
    endcase
    step(1);
    {frame_sent, pattern_detect, last_byte, buffer_overrun, rssi_valid} <= 5'h00;
    step(3);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize, op_mode} = '0;
    {xo_running, synth_lock_in, rssi_sampling_started, pa_ramp_done, rx_chain_done, rssi_valid} = '0;
    {intermediate_mode, pattern_detect, buffer_overrun, frame_sent, last_byte, buffer_count} = '0;
    {checksum_good, checksum_enable, checksum_fail_keep, continuous_mode} = '0;
    signal_strength_value = 8'hFF;
    buffer_mark = 7'h0A;
    hsize = 3'h2;
    step(10);
    hresetn <= 1'b1;
    step(1);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    wr(32'h94, 32'hA5);
    rd(32'h94, 32'hA5);
    wr(32'h98, 32'hFF);
    rd(32'h98, 32'hF7);
    wr(32'h98, 32'h06);
    step(3);
    chk("rc enable", rc_osc_enable, 1'b1);
    wr(32'h98, 32'h07);
    step(4);
    chk("clock pin off", {rc_osc_enable, divided_clock_pin}, 2'b00);
    op_mode <= 3'h2;
    step(3);
    rd(32'h9C, 32'h00);
    synth_lock_in <= 1'b1;
    step(3);
    rd(32'h9C, 32'h90);
    op_mode <= 3'h3;
    pa_ramp_done <= 1'b1;
    step(3);
    rd(32'h9C, 32'hB0);
    pulse(0);
    rd(32'hA0, 32'h08);
    op_mode <= 3'h2;
    step(3);
    rd(32'hA0, 32'h00);
    rd(32'h9C, 32'h90);
    wr(32'hA8, 32'h01);
    op_mode <= 3'h4;
    {rssi_sampling_started, rx_chain_done} <= 2'b11;
    step(3);
    rd(32'h9C, 32'hD0);
    step(30);
    rd(32'h9C, 32'hD0);
    step(40);
    rd(32'h9C, 32'hD4);
    signal_strength_value <= 8'h10;
    pulse(4);
    rd(32'h9C, 32'hDC);
    wr(32'h9C, 32'h08);
    rd(32'h9C, 32'hD4);
    pulse(1);
    wr(32'h9C, 32'h01);
    rd(32'h9C, 32'hD5);
    chk("pin0 pattern route", general_output_pin[0], 1'b1);
    continuous_mode <= 1'b1;
    wr(32'h9C, 32'h01);
    rd(32'h9C, 32'hD4);
    intermediate_mode <= 1'b1;
    step(3);
    rd(32'h9C, 32'hD6);
    intermediate_mode <= 1'b0;
    buffer_count <= 7'h42;
    step(3);
    rd(32'hA0, 32'hE0);
    buffer_count <= 7'h0A;
    step(3);
    rd(32'hA0, 32'h40);
    buffer_count <= 7'h00;
    step(3);
    rd(32'h9C, 32'hD0);
    buffer_count <= 7'h05;
    {checksum_enable, checksum_good} <= 2'b11;
    pulse(2);
    rd(32'hA0, 32'h46);
    buffer_count <= 7'h00;
    step(3);
    rd(32'hA0, 32'h00);
    buffer_count <= 7'h05;
    checksum_good <= 1'b0;
    f0 = flushes;
    pulse(2);
    chk("flush count", flushes, f0 + 1);
    rd(32'hA0, 32'h40);
    checksum_fail_keep <= 1'b1;
    pulse(2);
    rd(32'hA0, 32'h44);
    pulse(3);
    rd(32'hA0, 32'h54);
    f0 = flushes;
    wr(32'hA0, 32'h10);
    step(3);
    chk("flush count", flushes, f0 + 1);
    rd(32'hA0, 32'h40);
    op_mode <= 3'h0;
    step(2);
    pulse(3);
    rd(32'hA0, 32'h40);
    print_verdict;
  end
endmodule // tb_top

bind revf_flags revf_flags_properties chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .op_mode, .last_byte, .checksum_good, .checksum_enable, .checksum_fail_keep,
  .buffer_flush, .rx_restart);
